/* File: core/apb_bridge_error_monitor.sv */
// bridge from the system bus to the peripheral bus with error monitoring
`default_nettype none
module apb_bridge_error_monitor
   import apb_bridge_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  srst,
   input  wire logic                  sysReq,
   input  wire logic                  sysWrite,
   input  wire logic [SYS_ADDR_W-1:0] sysAddr,
   input  wire logic [31:0]           sysWdata,
   output logic                       sysReady,
   output logic                       sysDone,
   output logic                       sysAbort,
   output logic [31:0]                sysRdata,
   output logic [PAGE_COUNT-1:0]      PSEL,
   output logic                       PENABLE,
   output logic                       PWRITE,
   output logic [PAGE_ADDR_W-1:0]     PADDR,
   output logic [31:0]                PWDATA,
   input  wire logic [31:0]           PRDATA,
   input  wire logic                  PREADY
);
   bridge_state_t state;
   logic          timeoutFlag;
   logic          badAddressFlag;
   logic          abortFlag;
   logic          errorResponseEnable;
   logic [4:0]    waitLimitCount;
   logic [15:0]   badAddr;
   logic          badDir;
   logic [15:0]   toAddr;
   logic          toDir;
   logic [15:0]   curAddr;
   logic          take;
   logic          regHit;
   logic          badHit;
   logic          expired;
   logic          timeoutEvent;
   logic          abortEvent;
   logic          statusWrite;
   logic [31:0]   statusWord;
   logic [31:0]   regWord;

   function automatic logic [4:0] page_of(input logic [SYS_ADDR_W-1:0] a);
      page_of = a[SYS_ADDR_W-1:PAGE_ADDR_W];
   endfunction : page_of

   assign take     = sysReq && sysReady;
   assign sysReady = (state == ST_IDLE);
   assign regHit   = take && page_of(sysAddr) == REG_PAGE;
   // only the bridge page can be out of range
   assign badHit   = regHit && sysAddr[PAGE_ADDR_W-1:0] >= OFS_RESERVED_LO;
   assign timeoutEvent = (state == ST_ACCESS) && !PREADY && expired;
   // posted writes are already answered; only reads abort on time-out
   assign abortEvent   = errorResponseEnable && (badHit || (timeoutEvent && !PWRITE));
   assign statusWrite  = regHit && !badHit && sysWrite && sysAddr[PAGE_ADDR_W-1:0] == OFS_STATUS;

   apb_wait_timer u_timer (
      .clk_sys        (clk_sys),
      .srst           (srst),
      .start          (state == ST_SETUP),
      .run            (state == ST_ACCESS),
      .waitLimitCount (waitLimitCount),
      .expired        (expired)
   );

   // transfer sequencer
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state <= ST_IDLE;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (take && !regHit) begin
                  state <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               state <= ST_ACCESS;
            end
            ST_ACCESS: begin
               if (PREADY || timeoutEvent) begin
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // peripheral-side signals
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         PSEL    <= '0;
         PENABLE <= 1'b0;
         PWRITE  <= 1'b0;
         PADDR   <= '0;
         PWDATA  <= 32'h0000_0000;
         curAddr <= 16'h0000;
      end else if (take && !regHit) begin
         PSEL    <= PAGE_COUNT'(1) << page_of(sysAddr);
         PWRITE  <= sysWrite;
         PADDR   <= {sysAddr[PAGE_ADDR_W-1:2], 2'b00};
         PWDATA  <= sysWdata;
         curAddr <= 16'(sysAddr);
      end else if (state == ST_SETUP) begin
         PENABLE <= 1'b1;
      end else if (state == ST_ACCESS && (PREADY || timeoutEvent)) begin
         PSEL    <= '0;
         PENABLE <= 1'b0;
      end
   end

   // answer to the system bus
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         sysDone  <= 1'b0;
         sysAbort <= 1'b0;
         sysRdata <= 32'h0000_0000;
      end else begin
         sysDone  <= 1'b0;
         sysAbort <= 1'b0;
         if (regHit) begin
            sysDone  <= 1'b1;
            sysAbort <= abortEvent;
            sysRdata <= (sysWrite || badHit) ? 32'h0000_0000 : regWord;
         end else if (take && sysWrite) begin
            sysDone <= 1'b1;
         end else if (state == ST_ACCESS && !PWRITE && (PREADY || timeoutEvent)) begin
            sysDone  <= 1'b1;
            sysAbort <= abortEvent;
            sysRdata <= PREADY ? PRDATA : 32'h0000_0000;
         end
      end
   end

   // sticky flags, set wins over a clearing write
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         timeoutFlag    <= RESET_STATUS[STATUS_TIMEOUT];
         badAddressFlag <= RESET_STATUS[STATUS_BAD];
         abortFlag      <= RESET_STATUS[STATUS_ABORT];
      end else begin
         timeoutFlag    <= timeoutEvent || (timeoutFlag && !(statusWrite && sysWdata[STATUS_TIMEOUT]));
         badAddressFlag <= badHit || (badAddressFlag && !(statusWrite && sysWdata[STATUS_BAD]));
         abortFlag      <= abortEvent || (abortFlag && !(statusWrite && sysWdata[STATUS_ABORT]));
      end
   end

   // time-out control, reserved bits kept at zero
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         errorResponseEnable <= RESET_TIMEOUT[TOCTL_ENABLE];
         waitLimitCount      <= RESET_TIMEOUT[TOCTL_COUNT_MSB:0];
      end else if (regHit && !badHit && sysWrite && sysAddr[PAGE_ADDR_W-1:0] == OFS_TIMEOUT) begin
         errorResponseEnable <= sysWdata[TOCTL_ENABLE];
         waitLimitCount      <= sysWdata[TOCTL_COUNT_MSB:0];
      end
   end

   // first-error capture
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         badAddr <= RESET_CAPTURE[CAP_ADDR_MSB:CAP_ADDR_LSB];
         badDir  <= RESET_CAPTURE[CAP_DIR];
         toAddr  <= RESET_CAPTURE[CAP_ADDR_MSB:CAP_ADDR_LSB];
         toDir   <= RESET_CAPTURE[CAP_DIR];
      end else begin
         if (badHit && !badAddressFlag) begin
            badAddr <= 16'(sysAddr);
            badDir  <= sysWrite;
         end
         if (timeoutEvent && !timeoutFlag) begin
            toAddr <= curAddr;
            toDir  <= PWRITE;
         end
      end
   end

   always_comb begin
      statusWord                 = 32'h0000_0000;
      statusWord[STATUS_TIMEOUT] = timeoutFlag;
      statusWord[STATUS_BAD]     = badAddressFlag;
      statusWord[STATUS_ABORT]   = abortFlag;
      unique case (sysAddr[PAGE_ADDR_W-1:0])
         OFS_STATUS:      regWord = statusWord;
         OFS_TIMEOUT:     regWord = {23'h0, errorResponseEnable, 3'h0, waitLimitCount};
         OFS_BAD_CAPTURE: regWord = {8'h00, badAddr, badDir, 7'h00};
         OFS_TO_CAPTURE:  regWord = {8'h00, toAddr, toDir, 7'h00};
         default:         regWord = 32'h0000_0000;
      endcase
   end

   // checks
   AST_ONE_PAGE: assert property (@(posedge clk_sys) disable iff (srst)
      $onehot0(PSEL) && !PSEL[REG_PAGE]) else $error("bad peripheral select");
   AST_ALIGNED: assert property (@(posedge clk_sys) disable iff (srst)
      PENABLE |-> PADDR[1:0] == 2'b00) else $error("unaligned peripheral address");
   AST_REG_ANSWER: assert property (@(posedge clk_sys) disable iff (srst)
      regHit && !badHit && !sysWrite && sysAddr[PAGE_ADDR_W-1:0] == OFS_TIMEOUT
      |=> sysDone && sysRdata == {23'h0, errorResponseEnable, 3'h0, waitLimitCount})
      else $error("register read wrong");
   AST_W1C: assert property (@(posedge clk_sys) disable iff (srst)
      statusWrite && sysWdata[STATUS_BAD] && !badHit |=> !badAddressFlag) else $error("flag not cleared");
   AST_TO_FLAG: assert property (@(posedge clk_sys) disable iff (srst)
      timeoutEvent |=> timeoutFlag && state == ST_IDLE && PSEL == '0) else $error("time-out not handled");
   AST_BAD_FLAG: assert property (@(posedge clk_sys) disable iff (srst)
      badHit |=> badAddressFlag && sysDone) else $error("bad address not flagged");
   AST_NO_PERIPH_ERR: assert property (@(posedge clk_sys) disable iff (srst)
      take && !regHit && !badAddressFlag |=> !badAddressFlag) else $error("peripheral page flagged");
   AST_ABORT_FLAG: assert property (@(posedge clk_sys) disable iff (srst)
      sysAbort |-> abortFlag && (timeoutFlag || badAddressFlag)) else $error("abort without flag");
   AST_WRITE_NO_ABORT: assert property (@(posedge clk_sys) disable iff (srst)
      timeoutEvent && PWRITE |=> !sysDone && !sysAbort) else $error("posted write aborted");
   AST_ABORT_EN: assert property (@(posedge clk_sys) disable iff (srst)
      badHit && errorResponseEnable |=> sysAbort) else $error("abort missing");
   AST_NORMAL_END: assert property (@(posedge clk_sys) disable iff (srst)
      timeoutEvent && !PWRITE && !errorResponseEnable |=> sysDone && !sysAbort) else $error("abort while off");
   AST_COUNT_OFF: assert property (@(posedge clk_sys) disable iff (srst)
      waitLimitCount == COUNT_OFF |-> !timeoutEvent) else $error("time-out while disabled");
   AST_RESET_ZERO: assert property (@(posedge clk_sys)
      $past(srst) |-> statusWord == 32'h0 && !errorResponseEnable && waitLimitCount == 5'h0)
      else $error("reset value wrong");
   AST_BAD_HOLD: assert property (@(posedge clk_sys) disable iff (srst)
      $past(badAddressFlag) && !$past(srst) |-> $stable(badAddr) && $stable(badDir)) else $error("capture overwritten");
   AST_TO_HOLD: assert property (@(posedge clk_sys) disable iff (srst)
      $past(timeoutFlag) && !$past(srst) |-> $stable(toAddr) && $stable(toDir)) else $error("capture overwritten");
   AST_TO_BOUND: assert property (@(posedge clk_sys) disable iff (srst)
      state == ST_ACCESS && PREADY |-> !timeoutEvent ##1 state == ST_IDLE) else $error("completion missed");
   COV_READ_OK: cover property (@(posedge clk_sys) disable iff (srst) sysDone && !sysAbort && !PWRITE);
   COV_TIMEOUT_READ: cover property (@(posedge clk_sys) disable iff (srst) timeoutEvent && !PWRITE);
   COV_BAD_ABORT: cover property (@(posedge clk_sys) disable iff (srst) badHit && errorResponseEnable);
   COV_TO_CLEAR: cover property (@(posedge clk_sys) disable iff (srst)
      statusWrite && sysWdata[STATUS_TIMEOUT] && timeoutFlag);
endmodule : apb_bridge_error_monitor
`default_nettype wire

/* File: core/apb_bridge_pkg.sv */
// constants for the system-bus to peripheral-bus bridge
`default_nettype none
package apb_bridge_pkg;
   localparam int          PAGE_COUNT      = 32;
   localparam int          SYS_ADDR_W      = 15;
   localparam int          PAGE_ADDR_W     = 10;
   localparam logic [4:0]  REG_PAGE        = 5'h1f;
   localparam logic [9:0]  OFS_STATUS      = 10'h000;
   localparam logic [9:0]  OFS_TIMEOUT     = 10'h004;
   localparam logic [9:0]  OFS_BAD_CAPTURE = 10'h008;
   localparam logic [9:0]  OFS_TO_CAPTURE  = 10'h00c;
   localparam logic [9:0]  OFS_RESERVED_LO = 10'h010;
   localparam int          STATUS_ABORT    = 0;
   localparam int          STATUS_BAD      = 4;
   localparam int          STATUS_TIMEOUT  = 5;
   localparam int          TOCTL_ENABLE    = 8;
   localparam int          TOCTL_COUNT_MSB = 4;
   localparam int          CAP_ADDR_LSB    = 8;
   localparam int          CAP_ADDR_MSB    = 23;
   localparam int          CAP_DIR         = 7;
   localparam logic [31:0] RESET_STATUS    = 32'h0000_0000;
   localparam logic [31:0] RESET_TIMEOUT   = 32'h0000_0000;
   localparam logic [31:0] RESET_CAPTURE   = 32'h0000_0000;
   localparam logic [4:0]  COUNT_OFF       = 5'h00;
   typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_ACCESS} bridge_state_t;
endpackage : apb_bridge_pkg
`default_nettype wire

/* File: core/apb_wait_timer.sv */
// counts peripheral wait cycles against the programmed limit
`default_nettype none
module apb_wait_timer
   import apb_bridge_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       srst,
   input  wire logic       start,
   input  wire logic       run,
   input  wire logic [4:0] waitLimitCount,
   output logic            expired
);
   logic [4:0] count;

   // restarts with each transfer, advances during the access phase
   always_ff @(posedge clk_sys) begin
      if (srst || start) begin
         count <= 5'h00;
      end else if (run && count != 5'h1f) begin
         count <= count + 5'h01;
      end
   end

   // limit access cycles elapsed; zero limit never expires
   assign expired = run && (waitLimitCount != COUNT_OFF) && (count == waitLimitCount - 5'h01);
endmodule : apb_wait_timer
`default_nettype wire

/* File: tb/apb_slave_model.sv */
// peripheral slave model with programmable wait states
`default_nettype none
module apb_slave_model
   import apb_bridge_pkg::*;
(
   input  wire logic                   clk_sys,
   input  wire logic                   srst,
   input  wire logic [PAGE_COUNT-1:0]  PSEL,
   input  wire logic                   PENABLE,
   input  wire logic                   PWRITE,
   input  wire logic [PAGE_ADDR_W-1:0] PADDR,
   input  wire logic [31:0]            PWDATA,
   input  wire logic [4:0]             waitCycles,
   output logic [31:0]                 PRDATA,
   output logic                        PREADY
);
   logic        access;
   logic [4:0]  waitCnt;
   logic [31:0] storeWord;
   logic [31:0] lastData;
   assign access = (|PSEL) && PENABLE;
   // 5'h1f never completes
   assign PREADY = access && (waitCnt == waitCycles) && (waitCycles != 5'h1f);
   // bus not driven: show the inverse of the last value
   assign PRDATA = PREADY ? (storeWord ^ {22'h0, PADDR}) : ~lastData;
   always_ff @(posedge clk_sys) begin
      if (srst || !access) begin
         waitCnt <= 5'h00;
      end else if (waitCnt != 5'h1f) begin
         waitCnt <= waitCnt + 5'h01;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         storeWord <= 32'h0000_0000;
         lastData  <= 32'h0000_0000;
      end else begin
         if (PREADY) begin
            lastData <= PRDATA;
         end
         if (PREADY && PWRITE) begin
            storeWord <= PWDATA;
         end
      end
   end
endmodule : apb_slave_model
`default_nettype wire

/* File: tb/apb_bridge_error_monitor_tb_top.sv */
// testbench for the bridge error monitor
`default_nettype none
module apb_bridge_error_monitor_tb_top
   import apb_bridge_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic                   clk_sys, srst, sysReq, sysWrite, sysReady, sysDone, sysAbort;
   logic [SYS_ADDR_W-1:0]  sysAddr;
   logic [31:0]            sysWdata, sysRdata, PWDATA, PRDATA, rd;
   logic [PAGE_COUNT-1:0]  PSEL;
   logic                   PENABLE, PWRITE, PREADY, ab, dn;
   logic [PAGE_ADDR_W-1:0] PADDR;
   logic [4:0]             waitCycles;
   int                     error_cnt, samples_checked;
   apb_bridge_error_monitor i_dut (.clk_sys(clk_sys), .srst(srst), .sysReq(sysReq), .sysWrite(sysWrite),
      .sysAddr(sysAddr), .sysWdata(sysWdata), .sysReady(sysReady), .sysDone(sysDone), .sysAbort(sysAbort),
      .sysRdata(sysRdata), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY));
   apb_slave_model i_slave (.clk_sys(clk_sys), .srst(srst), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .waitCycles(waitCycles), .PRDATA(PRDATA), .PREADY(PREADY));
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // entered and left just after a rising edge; full 32-bit words only
   task automatic acc(input logic wr, input logic [14:0] a, input logic [31:0] wd);
      int i;
      dn = 1'b0;
      ab = 1'b0;
      rd = 32'hffff_ffff;
      // one idle edge between requests
      @(posedge clk_sys);
      #1;
      sysReq = 1'b1;
      sysWrite = wr;
      sysAddr = a;
      sysWdata = wd;
      @(posedge clk_sys);
      #1;
      sysReq = 1'b0;
      for (i = 0; i < 60; i++) begin
         if (sysDone === 1'b1) begin
            dn = 1'b1;
            ab = sysAbort;
            rd = sysRdata;
         end
         if (sysReady === 1'b1) break;
         @(posedge clk_sys);
         #1;
      end
      if (i == 60) begin
         error_cnt++;
         tally_and_finish();
      end
   endtask : acc
   initial begin
      repeat (5000) @(posedge clk_sys);
      error_cnt++;
      tally_and_finish();
   end
   initial begin
      {srst, sysReq, sysWrite, sysAddr, sysWdata} = '0;
      srst = 1'b1;
      waitCycles = 5'h03;
      error_cnt = 0;
      samples_checked = 0;
      repeat (5) @(posedge clk_sys);
      #1;
      srst = 1'b0;
      for (int k = 0; k < 4; k++) begin
         acc(1'b0, 15'h7c00 + 15'(4 * k), 32'h0);
         check("reset value", rd, 32'h0000_0000);
      end
      acc(1'b1, 15'h7c04, 32'h0000_0104);
      acc(1'b0, 15'h7c04, 32'h0);
      check("timeout control", rd, 32'h0000_0104);
      acc(1'b1, 15'h1408, 32'h1234_5678);
      check("posted write done", {31'h0, dn}, 32'h1);
      acc(1'b0, 15'h0c10, 32'h0);
      check("peripheral read", rd, 32'h1234_5668);
      check("peripheral abort", {31'h0, ab}, 32'h0);
      acc(1'b0, 15'h7c00, 32'h0);
      check("status quiet", rd, 32'h0000_0000);
      acc(1'b0, 15'h7c10, 32'h0);
      check("bad read abort", {31'h0, ab}, 32'h1);
      acc(1'b0, 15'h7c00, 32'h0);
      check("status bad", rd, 32'h0000_0011);
      acc(1'b1, 15'h7ffc, 32'h0);
      check("bad write abort", {31'h0, ab}, 32'h1);
      acc(1'b0, 15'h7c08, 32'h0);
      check("first capture", rd, 32'h007c_1000);
      acc(1'b1, 15'h7c00, 32'h0000_0010);
      acc(1'b0, 15'h7c00, 32'h0);
      check("partial clear", rd, 32'h0000_0001);
      acc(1'b1, 15'h7c00, 32'h0000_0001);
      acc(1'b1, 15'h7ffc, 32'h0);
      acc(1'b0, 15'h7c08, 32'h0);
      check("new capture", rd, 32'h007f_fc80);
      acc(1'b1, 15'h7c00, 32'h0000_0011);
      waitCycles = 5'h1f;
      acc(1'b0, 15'h0820, 32'h0);
      check("timeout read abort", {30'h0, dn, ab}, 32'h3);
      check("timeout read data", rd, 32'h0000_0000);
      acc(1'b0, 15'h7c00, 32'h0);
      check("status timeout", rd, 32'h0000_0021);
      acc(1'b1, 15'h1840, 32'h0);
      check("timeout write answer", {30'h0, dn, ab}, 32'h2);
      acc(1'b0, 15'h7c0c, 32'h0);
      check("timeout capture", rd, 32'h0008_2000);
      acc(1'b1, 15'h7c00, 32'h0000_0021);
      acc(1'b1, 15'h1840, 32'h0);
      acc(1'b0, 15'h7c00, 32'h0);
      check("write timeout status", rd, 32'h0000_0020);
      acc(1'b0, 15'h7c0c, 32'h0);
      check("timeout recapture", rd, 32'h0018_4080);
      acc(1'b1, 15'h7c00, 32'h0000_0020);
      acc(1'b1, 15'h7c04, 32'h0000_0004);
      acc(1'b0, 15'h7c10, 32'h0);
      check("bad read normal", {30'h0, dn, ab}, 32'h2);
      acc(1'b0, 15'h0820, 32'h0);
      check("timeout read normal", {30'h0, dn, ab}, 32'h2);
      acc(1'b0, 15'h7c00, 32'h0);
      check("status no abort", rd, 32'h0000_0030);
      acc(1'b1, 15'h7c00, 32'h0000_0030);
      acc(1'b1, 15'h7c04, 32'h0000_0100);
      waitCycles = 5'h14;
      acc(1'b0, 15'h0c10, 32'h0);
      check("limit off read", {30'h0, dn, ab}, 32'h2);
      check("limit off data", rd, 32'h1234_5668);
      acc(1'b0, 15'h7c00, 32'h0);
      check("limit off status", rd, 32'h0000_0000);
      // registers and captures nonzero, then a second reset
      acc(1'b1, 15'h7c10, 32'h0);
      srst = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      srst = 1'b0;
      for (int k = 0; k < 4; k++) begin
         acc(1'b0, 15'h7c00 + 15'(4 * k), 32'h0);
         check("mid-run reset value", rd, 32'h0000_0000);
      end
      tally_and_finish();
   end
endmodule : apb_bridge_error_monitor_tb_top
`default_nettype wire
